// ---- otp_page1_status.sv ----
// Page one status register with load and programming history tracking.
`timescale 1ns/1ps

module otp_page1_status
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [otp_page1_status_pkg::ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire otp_page1_status_pkg::load_result_t load_res,
   input wire otp_page1_status_pkg::prog_result_t prog_res,
   output logic programming_fault,
   output logic prog_allowed,
   output logic irq
);
   import otp_page1_status_pkg::*;

   logic loaded_q, warn_q, load_err_q, valid_q;
   logic low_clear_q, high_clear_q, try_q;
   logic fmt_fault;
   logic [7:0] status;
   logic [7:0] event_q, mask_q, events;
   logic fault_q, active_q;
   logic mine_start, refuse;

   ////////////////////////////////////////////////////////////////////////////
   // Status bits. Nothing written by software reaches them.

   assign fmt_fault = (low_clear_q | high_clear_q) & ~try_q;
   assign mine_start = prog_res.start & (prog_res.page_choice == PAGE_ONE);
   assign refuse = mine_start & (try_q | fmt_fault);
   assign prog_allowed = ~(try_q | fmt_fault);

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         loaded_q <= 1'b0;
         warn_q <= 1'b0;
         load_err_q <= 1'b0;
      end
      else if (load_res.done)
      begin
         loaded_q <= 1'b1;
         warn_q <= load_res.single_fixed & ~load_res.double_found;
         load_err_q <= load_res.double_found;
      end
   end

   // An attempt in flight belongs to page one only if accepted at its start.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         active_q <= 1'b0;
      else if (mine_start & ~refuse)
         active_q <= 1'b1;
      else if (prog_res.done)
         active_q <= 1'b0;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         try_q <= 1'b0;
      else if (mine_start & ~refuse)
         try_q <= 1'b1;
   end

   // The supply flags are active low: overvoltage pulls the low flag too.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         low_clear_q <= 1'b0;
         high_clear_q <= 1'b0;
         valid_q <= 1'b0;
      end
      else if (active_q & prog_res.done)
      begin
         low_clear_q <= ~(prog_res.supply_low | prog_res.supply_high);
         high_clear_q <= ~prog_res.supply_high;
         valid_q <= prog_res.success & ~prog_res.supply_low
                    & ~prog_res.supply_high;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         fault_q <= 1'b0;
      else if (refuse)
         fault_q <= 1'b1;
      else if (mine_start)
         fault_q <= 1'b0;
   end
   assign programming_fault = fault_q;

   assign status = {loaded_q, warn_q, load_err_q, fmt_fault,
                    valid_q, low_clear_q, high_clear_q, try_q};

   ////////////////////////////////////////////////////////////////////////////
   // Sticky events, cleared by writing one; a new event wins over the clear.

   always_comb
   begin
      events = 8'h00;
      events[EV_LOAD] = load_res.done;
      events[EV_PROG] = active_q & prog_res.done;
      events[EV_FAULT] = refuse;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         event_q <= EVENT_RESET;
      else if (wr && addr == EVENT_ADDR)
         event_q <= (event_q & ~wdata) | events;
      else
         event_q <= event_q | events;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         mask_q <= MASK_RESET;
      else if (wr && addr == MASK_ADDR)
         mask_q <= wdata;
   end

   assign irq = |(event_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data one cycle after the strobe, zero otherwise.

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         rdata <= 8'h00;
      else if (rd)
      begin
         unique case (addr)
            STATUS_ADDR: rdata <= status;
            EVENT_ADDR: rdata <= event_q;
            MASK_ADDR: rdata <= mask_q;
            CTRL_ADDR: rdata <= {6'h00, prog_allowed, fault_q};
            default: rdata <= 8'h00;
         endcase
      end
      else
         rdata <= 8'h00;
   end

endmodule : otp_page1_status

// ---- otp_page1_status_monitor.sv ----
// Port checker for the page one status block.
`timescale 1ns/1ps
module otp_page1_status_monitor
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [otp_page1_status_pkg::ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire otp_page1_status_pkg::load_result_t load_res,
   input wire otp_page1_status_pkg::prog_result_t prog_res,
   input wire logic programming_fault,
   input wire logic prog_allowed,
   input wire logic irq
);
   import otp_page1_status_pkg::*;
   logic sr, pg1;
   assign sr = rd && addr == STATUS_ADDR;
   assign pg1 = prog_res.start && !prog_res.page_choice;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   try_lock_a: assert property (pg1 && prog_allowed |=> !prog_allowed)
      else $error("start not locked");
   take_a: assert property (pg1 && prog_allowed |=> !programming_fault)
      else $error("good start faulted");
   refuse_a: assert property (pg1 && !prog_allowed |=> programming_fault)
      else $error("bad start taken");
   page_two_a: assert property (prog_res.start && prog_res.page_choice
      |=> $stable(prog_allowed)) else $error("page two start acted");
   try_stick_a: assert property (!$rose(prog_allowed))
      else $error("attempt flag cleared");
   fmt_flag_a: assert property (sr |=> rdata[4] == (|rdata[2:1] & !rdata[0]))
      else $error("format flag wrong");
   uv_with_ov_a: assert property (sr |=> !rdata[2] || rdata[1])
      else $error("overvoltage without undervoltage");
   valid_ok_a: assert property (sr |=> !rdata[3] || &rdata[2:0])
      else $error("valid without clean attempt");
endmodule : otp_page1_status_monitor
bind otp_page1_status otp_page1_status_monitor mon (.clk, .reset, .addr,
   .wdata, .wr, .rd, .rdata, .load_res, .prog_res, .programming_fault,
   .prog_allowed, .irq);

// ---- otp_page1_status_pkg.sv ----
// Package with register map, field positions and event layout for the page one status block.
package otp_page1_status_pkg;

   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h51A;
   localparam logic [ADDR_W-1:0] EVENT_ADDR = 12'h520;
   localparam logic [ADDR_W-1:0] MASK_ADDR = 12'h521;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h522;

   localparam int LOADED_BIT = 7;
   localparam int WARN_BIT = 6;
   localparam int LOAD_ERR_BIT = 5;
   localparam int FMT_BIT = 4;
   localparam int VALID_BIT = 3;
   localparam int LOW_CLEAR_BIT = 2;
   localparam int HIGH_CLEAR_BIT = 1;
   localparam int TRY_BIT = 0;

   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] EVENT_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic PAGE_ONE = 1'b0;

   // Event bits: 0 load done, 1 programming done, 2 programming refused.
   localparam int EV_LOAD = 0;
   localparam int EV_PROG = 1;
   localparam int EV_FAULT = 2;

   typedef struct packed {
      logic done;
      logic single_fixed;
      logic double_found;
   } load_result_t;

   typedef struct packed {
      logic start;
      logic page_choice;
      logic done;
      logic success;
      logic supply_low;
      logic supply_high;
   } prog_result_t;

endpackage : otp_page1_status_pkg

// ---- otp_page1_status_tb_top.sv ----
// Self-checking bench for the page one status block.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
   fail_count++; $display("Error %s exp %h got %h", n, e, s); end end
module otp_page1_status_tb_top;
   import otp_page1_status_pkg::*;
   logic clk = 0, reset = 1, wr = 0, rd = 0, pend = 0;
   logic programming_fault, prog_allowed, irq;
   logic [ADDR_W-1:0] addr = '0;
   logic [7:0] wdata = '0, rdata, e, expq[$];
   logic [2:0] r;
   load_result_t load_res = '0;
   prog_result_t prog_res = '0;
   int fail_count = 0, n_compared = 0;
   always #4 clk = ~clk;
   otp_page1_status dut (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
      .load_res, .prog_res, .programming_fault, .prog_allowed, .irq);
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 0;
      rd <= 0;
      @(negedge clk);
   endtask : bus
   task automatic rdx(input logic [11:0] a, input logic [7:0] x);
      expq.push_back(x);
      bus(0, a, 8'h00);
   endtask : rdx
   task automatic drv(input logic [2:0] l, input logic [5:0] p);
      @(posedge clk);
      load_res <= l;
      prog_res <= p;
      @(posedge clk);
      load_res <= '0;
      prog_res <= '0;
      @(negedge clk);
   endtask : drv
   task conclude;
      $display("Compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude
   // Read data stand only one cycle, so the check runs on that edge.
   always @(posedge clk)
   begin
      if (pend)
      begin
         e = expq.pop_front();
         `CHK("rdata", e, rdata)
      end
      pend <= rd;
   end
   initial
   begin
      void'($urandom(81389));
      for (int i = 0; i < 4; i++)
      begin
         r = 3'($urandom);
         reset <= 1;
         repeat (2) @(posedge clk);
         reset <= 0;
         bus(1, STATUS_ADDR, 8'hFF);
         rdx(STATUS_ADDR, 8'h00);
         `CHK("prog_allowed", 1'b1, prog_allowed)
         bus(1, MASK_ADDR, 8'h07);
         drv({1'b1, r[1:0]}, 6'h00);
         `CHK("irq", 1'b1, irq)
         drv(3'h0, 6'h30);
         rdx(CTRL_ADDR, 8'h02);
         drv(3'h0, 6'h20);
         drv(3'h0, {3'b001, r[2], i[0], i[1]});
         rdx(STATUS_ADDR, {1'b1, r[1] & ~r[0], r[0], 1'b0,
            r[2] & ~|i[1:0], ~|i[1:0], ~i[1], 1'b1});
         drv(3'h0, 6'h20);
         `CHK("prog_allowed", 1'b0, prog_allowed)
         `CHK("programming_fault", 1'b1, programming_fault)
         rdx(CTRL_ADDR, 8'h01);
         rdx(EVENT_ADDR, 8'h07);
         bus(1, MASK_ADDR, 8'h00);
         `CHK("irq", 1'b0, irq)
         bus(1, EVENT_ADDR, 8'h07);
         rdx(EVENT_ADDR, 8'h00);
         rdx(12'h7FF, 8'h00);
         repeat (2) @(posedge clk);
      end
      conclude();
   end
   initial
   begin
      #50us;
      fail_count++;
      conclude();
   end
endmodule : otp_page1_status_tb_top
